// *** rtl/config_pin_control.sv ***
// Pin control around configuration, readback and mode latching.
// Assumes all pins synchronous to pclk; pads resolve output enables.
`timescale 1ns/1ps
`include "cfg_pin_defines.svh"
// Overview of operation
// - Control input has a pull-up that is always enabled.
// - During configuration a low control input tri-states all user I/O.
// - After configuration an option decides if the input still tri-states I/O.
// - After configuration, with readback enabled, a falling edge starts readback at frame 0.
// - Readback data leaves on the shared serial pin; scan mode sends test data.
// - Configuration error output goes low on RAM or core init errors during configuration.
// - After configuration, with host port in use, error output becomes host interrupt, active low.
// - Mode pins are captured on the init rising edge and pick the mode.
// - Mode pins pulled up during configuration, become user I/O afterwards.
// - PLL clock pins tri-stated with pull-ups, user I/O when PLL unused.
// - Init pin held low open-drain while clearing; external low waits.
module config_pin_control
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Readback and configuration control pin
	input  wire logic        rd_cfg_in,
	output logic             rd_cfg_pullup,
	output logic             global_io_tristate,
	// Shared serial output
	input  wire logic        scan_tdo,
	output logic             rd_data_out,
	// Error or host interrupt pin
	input  wire logic        ram_init_err,
	input  wire logic        core_init_err,
	input  wire logic        host_irq_req,
	output logic             host_port_irq_n,
	// Init pin, open drain
	input  wire logic        init_in,
	output logic             init_out,
	output logic             init_oe,
	input  wire logic        mem_clear_busy,
	// Mode pins
	input  wire logic [3:0]  mode_pins,
	output logic             mode_pullup,
	output logic             mode_user_io,
	output logic [3:0]       cfg_mode,
	// PLL clock pins
	output logic [7:0]       pll_clock_pins_pullup,
	output logic [7:0]       pll_clock_pins_user_io,
	// Configuration memory readback
	input  wire logic [31:0] rd_word,
	output logic [15:0]      rd_frame,
	// Interrupt
	output logic             irq
);
	// ================================================================
	// Registers
	cfg_pin_pkg::phase_e phase_ff;
	cfg_pin_pkg::phase_e nxt_phase;
	logic [31:0]         ctrl_ff;
	logic [3:0]          irq_stat_ff;
	logic [3:0]          irq_mask_ff;
	logic [1:0]          err_src_ff;
	logic [3:0]          mode_ff;
	logic                init_d_ff;
	logic                rdcfg_d_ff;
	logic                rd_data_ff;
	logic                irq_n_ff;
	logic [31:0]         prdata_ff;

	readback_if rb ();

	readback_shifter u_shifter
	(
		.pclk    (pclk),
		.presetn (presetn),
		.rb      (rb),
		.rd_word (rd_word)
	);

	// ================================================================
	// Decoding
	wire       wr_en      = psel && penable && pwrite;
	wire       rd_en      = psel && penable && !pwrite;
	wire       sel_ctrl   = (paddr == `OFS_CTRL);
	wire       sel_status = (paddr == `OFS_STATUS);
	wire       sel_istat  = (paddr == `OFS_IRQ_STAT);
	wire       sel_imask  = (paddr == `OFS_IRQ_MASK);
	wire       sel_esrc   = (paddr == `OFS_ERR_SRC);
	wire       sel_rbadr  = (paddr == `OFS_RB_ADDR);
	wire       mapped     = sel_ctrl | sel_status | sel_istat | sel_imask | sel_esrc
	                        | sel_rbadr;
	wire       cfg_done   = ctrl_ff[`CTRL_CFG_DONE];
	wire       ts_opt     = ctrl_ff[`CTRL_TS_OPT];
	wire       rb_opt     = ctrl_ff[`CTRL_RB_OPT];
	wire       scan_en    = ctrl_ff[`CTRL_SCAN_EN];
	wire       host_en    = ctrl_ff[`CTRL_HOST_EN];
	wire [7:0] pll_used   = ctrl_ff[`CTRL_PLL0_USE +: `NUM_PLL_PINS];
	wire       configuring = (phase_ff != cfg_pin_pkg::PH_USER);
	wire       init_rise  = init_in && !init_d_ff;
	wire       rdcfg_fall = !rd_cfg_in && rdcfg_d_ff;
	// Once in user phase the pin only matters through an enabled option
	wire       rb_trigger = (phase_ff == cfg_pin_pkg::PH_USER) && rb_opt && rdcfg_fall
	                        && !rb.busy;
	wire       err_now    = ram_init_err | core_init_err;
	wire [3:0] irq_events = {init_rise, err_now && configuring, rb.done, rb_trigger};
	wire [3:0] istat_clr  = (wr_en && sel_istat) ? pwdata[3:0] : 4'h0;
	wire [3:0] status_val = {phase_ff, rb.busy, init_in};

	// ================================================================
	// Phase sequencing
	always_comb
	begin
		nxt_phase = phase_ff;
		case (phase_ff)
			cfg_pin_pkg::PH_INIT_HOLD: if (init_rise) nxt_phase = cfg_pin_pkg::PH_CONFIG;
			cfg_pin_pkg::PH_CONFIG:    if (cfg_done) nxt_phase = cfg_pin_pkg::PH_USER;
			cfg_pin_pkg::PH_USER:      if (!cfg_done) nxt_phase = cfg_pin_pkg::PH_INIT_HOLD;
			default:                   nxt_phase = cfg_pin_pkg::PH_INIT_HOLD;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_ff   <= cfg_pin_pkg::PH_INIT_HOLD;
			init_d_ff  <= 1'b0;
			rdcfg_d_ff <= 1'b1;
			mode_ff    <= 4'hF;
		end
		else
		begin
			phase_ff   <= nxt_phase;
			init_d_ff  <= init_in;
			rdcfg_d_ff <= rd_cfg_in;
			if (init_rise && phase_ff == cfg_pin_pkg::PH_INIT_HOLD)
				mode_ff <= mode_pins;
		end
	end

	// ================================================================
	// Register file
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_ff <= `CTRL_RESET;
		else if (wr_en && sel_ctrl)
			ctrl_ff <= pwdata;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_mask_ff <= `IRQ_RESET;
		else if (wr_en && sel_imask)
			irq_mask_ff <= pwdata[3:0];
	end

	// Set wins over a same-cycle write-one clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_stat_ff <= `IRQ_RESET;
		else
			irq_stat_ff <= (irq_stat_ff & ~istat_clr) | irq_events;
	end

	// Sticky error sources, cleared by write-one, set wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			err_src_ff <= 2'h0;
		else
			err_src_ff <= (err_src_ff & ~((wr_en && sel_esrc) ? pwdata[1:0] : 2'h0))
			              | ({core_init_err, ram_init_err} & {2{configuring}});
	end

	always_comb
	begin
		prdata = prdata_ff;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_ff <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata_ff <= sel_ctrl   ? ctrl_ff :
			             sel_status ? {24'h000000, mode_ff, status_val} :
			             sel_istat  ? {28'h0000000, irq_stat_ff} :
			             sel_imask  ? {28'h0000000, irq_mask_ff} :
			             sel_esrc   ? {30'h00000000, err_src_ff} :
			             sel_rbadr  ? {16'h0000, rb.frame} : 32'h0000_0000;
	end

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// ================================================================
	// Pins
	assign rb.start      = rb_trigger;
	assign rd_frame      = rb.frame;
	assign rd_cfg_pullup = 1'b1;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			global_io_tristate <= 1'b1;
			rd_data_ff         <= 1'b0;
			irq_n_ff           <= 1'b1;
		end
		else
		begin
			if (configuring)
				global_io_tristate <= !rd_cfg_in;
			else
				global_io_tristate <= ts_opt && !rd_cfg_in;
			rd_data_ff <= scan_en ? scan_tdo : (rb.busy ? rb.bit_out : 1'b0);
			if (host_en && !configuring)
				irq_n_ff <= !host_irq_req;
			else
				irq_n_ff <= !(configuring && err_now);
		end
	end

	assign rd_data_out     = rd_data_ff;
	assign host_port_irq_n = irq_n_ff;
	// Open drain: drive low only while memory clears in the hold phase
	assign init_oe         = (phase_ff == cfg_pin_pkg::PH_INIT_HOLD) && mem_clear_busy;
	assign init_out        = 1'b0;
	assign cfg_mode        = mode_ff;
	assign mode_pullup     = configuring;
	assign mode_user_io    = !configuring;
	assign pll_clock_pins_pullup  = {8{configuring}};
	assign pll_clock_pins_user_io = configuring ? 8'h00 : ~pll_used;
	assign irq             = |(irq_stat_ff & irq_mask_ff);
endmodule : config_pin_control

// *** rtl/cfg_pin_defines.svh ***
// Constants for the configuration pin control block.
// Assumes inclusion by bare name; definitions only.
`ifndef CFG_PIN_DEFINES_SVH
`define CFG_PIN_DEFINES_SVH
// ================================================================
// Register offsets (byte addresses)
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_IRQ_STAT    12'h008
`define OFS_IRQ_MASK    12'h00C
`define OFS_ERR_SRC     12'h010
`define OFS_RB_ADDR     12'h014
// ================================================================
// Control register fields
`define CTRL_CFG_DONE   0
`define CTRL_TS_OPT     1
`define CTRL_RB_OPT     2
`define CTRL_SCAN_EN    3
`define CTRL_HOST_EN    4
`define CTRL_PLL0_USE   8
`define CTRL_RESET      32'h0000_0000
// ================================================================
// Interrupt status fields
`define IRQ_RB_START    0
`define IRQ_RB_DONE     1
`define IRQ_CFG_ERR     2
`define IRQ_MODE_LATCH  3
`define IRQ_RESET       4'h0
// ================================================================
// Readback geometry
`define RB_FRAME_BITS   32
`define RB_FRAMES       16'h0010
`define RB_FIRST_FRAME  16'h0000
`define NUM_PLL_PINS    8
`endif

// *** rtl/cfg_pin_pkg.sv ***
// Types for the configuration pin control block.
// Assumes nothing beyond the defines header.
package cfg_pin_pkg;
	typedef enum logic [1:0] {
		PH_INIT_HOLD,
		PH_CONFIG,
		PH_USER
	} phase_e;
	typedef enum logic [1:0] {
		RB_IDLE,
		RB_SHIFT,
		RB_NEXT
	} rb_state_e;
endpackage : cfg_pin_pkg

// *** rtl/readback_if.sv ***
// Interface between the control core and the readback shifter.
// Assumes one clock, pclk, shared by both ends.
`timescale 1ns/1ps
interface readback_if;
	logic        start;
	logic        busy;
	logic        done;
	logic [15:0] frame;
	logic        bit_out;
	modport ctrl (output start, input busy, input done, input frame, input bit_out);
	modport shifter (input start, output busy, output done, output frame, output bit_out);
endinterface : readback_if

// *** rtl/readback_shifter.sv ***
// Serialises configuration frames from frame address 0 upward.
// Assumes frame data arrives from the configuration memory on rd_word.
`timescale 1ns/1ps
`include "cfg_pin_defines.svh"
module readback_shifter
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Control side
	readback_if.shifter      rb,
	// Configuration memory
	input  wire logic [31:0] rd_word
);
	// ================================================================
	// State
	cfg_pin_pkg::rb_state_e state_ff;
	cfg_pin_pkg::rb_state_e nxt_state;
	logic [15:0]            frame_ff;
	logic [4:0]             bit_ff;
	logic [31:0]            shreg_ff;
	logic                   done_ff;
	wire                    last_bit   = (bit_ff == 5'(`RB_FRAME_BITS - 1));
	wire                    last_frame = (frame_ff == (`RB_FRAMES - 16'h0001));

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			// Each frame is loaded in RB_NEXT after its address has settled
			cfg_pin_pkg::RB_IDLE:  if (rb.start) nxt_state = cfg_pin_pkg::RB_NEXT;
			cfg_pin_pkg::RB_SHIFT: if (last_bit) nxt_state = last_frame ? cfg_pin_pkg::RB_IDLE
			                                                            : cfg_pin_pkg::RB_NEXT;
			cfg_pin_pkg::RB_NEXT:  nxt_state = cfg_pin_pkg::RB_SHIFT;
			default:               nxt_state = cfg_pin_pkg::RB_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= cfg_pin_pkg::RB_IDLE;
			frame_ff <= 16'h0000;
			bit_ff   <= 5'h00;
			shreg_ff <= 32'h0000_0000;
			done_ff  <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			done_ff  <= (state_ff == cfg_pin_pkg::RB_SHIFT) && last_bit && last_frame;
			if (state_ff == cfg_pin_pkg::RB_IDLE && rb.start)
			begin
				frame_ff <= `RB_FIRST_FRAME;
				bit_ff   <= 5'h00;
			end
			else if (state_ff == cfg_pin_pkg::RB_SHIFT)
			begin
				bit_ff   <= bit_ff + 5'h01;
				shreg_ff <= {shreg_ff[30:0], 1'b0};
				if (last_bit && !last_frame)
					frame_ff <= frame_ff + 16'h0001;
			end
			else if (state_ff == cfg_pin_pkg::RB_NEXT)
			begin
				bit_ff   <= 5'h00;
				shreg_ff <= rd_word;
			end
		end
	end

	assign rb.busy    = (state_ff != cfg_pin_pkg::RB_IDLE);
	assign rb.done    = done_ff;
	assign rb.frame   = frame_ff;
	assign rb.bit_out = shreg_ff[31];
endmodule : readback_shifter

// *** sim/config_pin_control_properties.sv ***
// Concurrent checks on the configuration pin control block.
// Assumes a bind to config_pin_control; options tracked from APB writes.
`timescale 1ns/1ps
`include "cfg_pin_defines.svh"
module config_pin_control_properties
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// Register bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// Pins
	input wire logic        rd_cfg_in,
	input wire logic        rd_cfg_pullup,
	input wire logic        global_io_tristate,
	input wire logic        scan_tdo,
	input wire logic        rd_data_out,
	input wire logic        ram_init_err,
	input wire logic        core_init_err,
	input wire logic        host_irq_req,
	input wire logic        host_port_irq_n,
	input wire logic        init_in,
	input wire logic        init_out,
	input wire logic        init_oe,
	input wire logic        mem_clear_busy,
	input wire logic [3:0]  mode_pins,
	input wire logic        mode_pullup,
	input wire logic        mode_user_io,
	input wire logic [3:0]  cfg_mode,
	input wire logic [7:0]  pll_clock_pins_user_io,
	input wire logic [15:0] rd_frame
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic [4:0] ctrl_ff;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			ctrl_ff <= 5'h00;
		else if (psel && penable && pwrite && paddr == `OFS_CTRL)
			ctrl_ff <= pwdata[4:0];
	sequence init_rise;
		$rose(init_in) && !mode_user_io;
	endsequence
	sequence rb_fall;
		$fell(rd_cfg_in) && mode_user_io && ctrl_ff[2];
	endsequence
	pullup_on_a: assert property (
		rd_cfg_pullup) else $error("control pull-up off");
	ts_config_a: assert property (
		!$past(mode_user_io) && !$past(rd_cfg_in) |-> global_io_tristate)
		else $error("no tri-state in configuration");
	ts_user_a: assert property (
		$past(mode_user_io) |->
		global_io_tristate == ($past(ctrl_ff[1]) && !$past(rd_cfg_in)))
		else $error("user tri-state wrong");
	rb_start_a: assert property (
		rb_fall |-> ##[0:2] rd_frame == 16'h0000) else $error("readback not at frame 0");
	scan_out_a: assert property (
		$past(ctrl_ff[3]) |-> rd_data_out == $past(scan_tdo)) else $error("scan data lost");
	cfg_err_a: assert property (
		!$past(mode_user_io) && $past(ram_init_err || core_init_err) |-> !host_port_irq_n)
		else $error("error not flagged");
	host_irq_a: assert property (
		$past(mode_user_io && ctrl_ff[4]) |-> host_port_irq_n == !$past(host_irq_req))
		else $error("host interrupt wrong");
	mode_latch_a: assert property (
		init_rise |-> ##[0:2] cfg_mode == mode_pins) else $error("mode not latched");
	mode_pins_a: assert property (
		mode_pullup != mode_user_io) else $error("mode pin control wrong");
	pll_cfg_a: assert property (
		!mode_user_io |-> pll_clock_pins_user_io == 8'h00) else $error("PLL pins freed early");
	init_hold_a: assert property (
		init_oe |-> !init_out && mem_clear_busy && !mode_user_io) else $error("init pulled wrongly");
endmodule : config_pin_control_properties
bind config_pin_control config_pin_control_properties u_config_pin_control_properties (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .rd_cfg_in, .rd_cfg_pullup,
	.global_io_tristate, .scan_tdo, .rd_data_out, .ram_init_err, .core_init_err,
	.host_irq_req, .host_port_irq_n, .init_in, .init_out, .init_oe, .mem_clear_busy,
	.mode_pins, .mode_pullup, .mode_user_io, .cfg_mode, .pll_clock_pins_user_io, .rd_frame);

// *** sim/cfg_host_model.sv ***
// External configuration controller and configuration memory model.
// Assumes the bench commands init release and control-pin pulses.
`timescale 1ns/1ps
module cfg_host_model
(
	// Bench commands
	input  wire logic        rel,
	input  wire logic        rb_low,
	input  wire logic [3:0]  mode_sel,
	// Device pins
	input  wire logic        init_oe,
	input  wire logic [15:0] rd_frame,
	output logic             init_in,
	output logic             rd_cfg_in,
	output logic [3:0]       mode_pins,
	output logic [31:0]      rd_word
);
	// Open-drain init line with pull-up
	assign init_in   = rel && !init_oe;
	// Control pin held high until init is seen high
	assign rd_cfg_in = !(rb_low && init_in);
	assign mode_pins = mode_sel;
	assign rd_word   = {~rd_frame, rd_frame};
endmodule : cfg_host_model

// *** sim/tb_config_pin_control.sv ***
// Self-checking bench for the configuration pin control block.
// Assumes the host model drives init, control and mode pins.
`timescale 1ns/1ps
`include "cfg_pin_defines.svh"
module tb_config_pin_control;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd_word, word;
	logic pready, pslverr, rd_cfg_in, rd_cfg_pullup, global_io_tristate, rd_data_out;
	logic scan_tdo = 1'h0, ram_init_err = 1'h0, core_init_err = 1'h0, host_irq_req = 1'h0;
	logic host_port_irq_n, init_in, init_out, init_oe, mode_pullup, mode_user_io, irq;
	logic mem_clear_busy = 1'h0, rel = 1'h0, rb_low = 1'h0, s, h;
	logic [3:0] mode_pins, cfg_mode, mode_sel = 4'h0;
	logic [7:0] pll_clock_pins_pullup, pll_clock_pins_user_io;
	logic [15:0] rd_frame;
	logic [32:0] exp_q[$];
	int fails = 0, checks_done = 0, n;
	always #12.5 pclk = ~pclk;
	config_pin_control u_config_pin_control (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .rd_cfg_in, .rd_cfg_pullup,
		.global_io_tristate, .scan_tdo, .rd_data_out, .ram_init_err, .core_init_err,
		.host_irq_req, .host_port_irq_n, .init_in, .init_out, .init_oe, .mem_clear_busy,
		.mode_pins, .mode_pullup, .mode_user_io, .cfg_mode, .pll_clock_pins_pullup,
		.pll_clock_pins_user_io, .rd_word, .rd_frame, .irq);
	cfg_host_model u_cfg_host_model (.rel, .rb_low, .mode_sel, .init_oe, .rd_frame,
		.init_in, .rd_cfg_in, .mode_pins, .rd_word);
	// ====
	// Checking and bus tasks
	task automatic tally_and_finish;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [32:0] got, input logic [32:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic lim(input int k);
		if (n >= k)
		begin
			fails++;
			tally_and_finish();
		end
	endtask : lim
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do @(posedge pclk); while (pready !== 1'h1 && ++n < 20);
		lim(20);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'h0, a, 32'h0);
	endtask : rd
	always @(posedge pclk)
		if (psel && penable && pready && !pwrite)
			chk("prdata", {pslverr, prdata}, exp_q.pop_front());
	// ====
	// Main sequence
	initial
	begin
		void'($urandom(32'h9F21308B));
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		rd(`OFS_CTRL, 33'h0);
		rd(`OFS_IRQ_STAT, 33'h0);
		rd(12'h018, 33'h1_0000_0000);
		mem_clear_busy <= 1'h1;
		rel <= 1'h1;
		mode_sel <= 4'($urandom);
		repeat (3) @(posedge pclk);
		chk("init", init_in, 33'h0);
		chk("init_oe", {init_oe, init_out}, 33'h2);
		chk("pll_pu", pll_clock_pins_pullup, 33'hFF);
		mem_clear_busy <= 1'h0;
		repeat (4) @(posedge pclk);
		chk("mode", cfg_mode, mode_sel);
		rd(`OFS_STATUS, {25'h0, mode_sel, 2'h1, 1'h0, 1'h1});
		rb_low <= 1'h1;
		repeat (3) @(posedge pclk);
		chk("ts_cfg", global_io_tristate, 33'h1);
		rb_low <= 1'h0;
		ram_init_err <= 1'h1;
		repeat (3) @(posedge pclk);
		chk("ts_cfg", global_io_tristate, 33'h0);
		chk("cfg_err", host_port_irq_n, 33'h0);
		ram_init_err <= 1'h0;
		rd(`OFS_IRQ_STAT, 33'hC);
		apb(1'h1, `OFS_IRQ_STAT, 32'hC);
		apb(1'h1, `OFS_CTRL, 32'h0F01);
		rb_low <= 1'h1;
		repeat (3) @(posedge pclk);
		chk("pll", pll_clock_pins_user_io, 33'hF0);
		chk("mode_io", {mode_user_io, mode_pullup}, 33'h2);
		chk("ts_off", global_io_tristate, 33'h0);
		chk("pll_pu", pll_clock_pins_pullup, 33'h0);
		rb_low <= 1'h0;
		rd(`OFS_IRQ_STAT, 33'h0);
		apb(1'h1, `OFS_CTRL, 32'h0F07);
		apb(1'h1, `OFS_IRQ_MASK, 32'h2);
		rb_low <= 1'h1;
		n = 0;
		do @(negedge pclk); while (rd_data_out !== 1'h1 && ++n < 10);
		lim(10);
		chk("ts_user", global_io_tristate, 33'h1);
		for (int f = 0; f < 2; f++)
		begin
			for (int b = 31; b >= 0; b--)
			begin
				word[b] = rd_data_out;
				@(negedge pclk);
			end
			@(negedge pclk);
			chk("frame", word, {~f[15:0], f[15:0]});
		end
		rb_low <= 1'h0;
		n = 0;
		do @(posedge pclk); while (irq !== 1'h1 && ++n < 700);
		lim(700);
		apb(1'h1, `OFS_IRQ_MASK, 32'h0);
		repeat (2) @(posedge pclk);
		chk("irq_masked", irq, 33'h0);
		apb(1'h1, `OFS_IRQ_MASK, 32'h2);
		repeat (2) @(posedge pclk);
		chk("irq_set", irq, 33'h1);
		apb(1'h1, `OFS_IRQ_STAT, 32'h3);
		repeat (2) @(posedge pclk);
		chk("irq_clear", irq, 33'h0);
		apb(1'h1, `OFS_CTRL, 32'h0F19);
		for (int i = 0; i < 8; i++)
		begin
			{s, h} = 2'($urandom);
			scan_tdo <= s;
			host_irq_req <= h;
			repeat (2) @(posedge pclk);
			chk("tdo", rd_data_out, s);
			chk("host_irq", host_port_irq_n, !h);
		end
		tally_and_finish();
	end
endmodule : tb_config_pin_control
